//--- ltc_pkg.sv
package ltc_pkg;
    // Register offsets
    localparam logic [7:0] LTC_OFF_RESULT = 8'h00;
    localparam logic [7:0] LTC_OFF_CONFIG = 8'h01;
    localparam logic [7:0] LTC_OFF_LOW = 8'h02;
    localparam logic [7:0] LTC_OFF_HIGH = 8'h03;
    // Configuration field positions
    localparam int LTC_CFG_RANGE_LSB = 12;
    localparam int LTC_CFG_HIGH_FLAG = 6;
    localparam int LTC_CFG_LOW_FLAG = 5;
    localparam int LTC_CFG_LATCH = 4;
    localparam int LTC_CFG_MASK = 2;
    localparam int LTC_CFG_FAULT_LSB = 0;
    // Limit and result field positions
    localparam int LTC_EXP_LSB = 12;
    localparam int LTC_MANT_W = 12;
    // Reset values and the automatic range code
    localparam logic [3:0] LTC_RANGE_RST = 4'hc;
    localparam logic [3:0] LTC_RANGE_AUTO = 4'hc;
    localparam logic LTC_MASK_RST = 1'b0;
    localparam logic [1:0] LTC_FAULT_RST = 2'h0;
    localparam logic [15:0] LTC_LOW_RST = 16'h0000;
    localparam logic [15:0] LTC_HIGH_RST = 16'hbfff;
    // Reserved bit that always reads as one
    localparam logic LTC_LATCH_VAL = 1'b1;
    // Width of a value brought to the common lux scale
    localparam int LTC_LUX_W = 27;
endpackage

//--- ltc_fault_counter.sv
`timescale 1ns/10ps
module ltc_fault_counter
    import ltc_pkg::*;
#(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Evaluation
    input wire logic eval,
    input wire logic violate,
    input wire logic [1:0] fault_count_sel,
    // Result
    output logic flag
);
    // A count of eight must fit, with room for the compare
    if (CNT_W < 4) begin : g_cnt_w_check
        $error("ltc_fault_counter: CNT_W must be at least 4");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic flag_reg;
    logic flag_next;
    logic [CNT_W-1:0] need;

    always_comb begin
        need = CNT_W'(1) << fault_count_sel;
        cnt_next = cnt_reg;
        flag_next = flag_reg;
        if (eval) begin
            if (violate) begin
                if (cnt_reg < need) begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
                flag_next = (cnt_reg + CNT_W'(1)) >= need;
            end else begin
                cnt_next = '0;
                flag_next = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule

//--- ltc_threshold.sv
// Notes on behaviour
// - Masked manual range reports result exponent zero
// - Masking touches result register only, not comparisons
// - Mask bit config bit 2, resets 0
// - Fault code 00/01/10/11 needs 1/2/4/8 faults
// - Fault field config bits 1:0, resets 00
// - Low limit at 02h: exponent 15:12, mantissa 11:0
// - Low limit resets to exponent 0, mantissa 000
// - Low mantissa is unsigned straight binary
// - Low lux equals 0.01 times 2^exp times mantissa
// - Exponents 0..11 double full scale and LSB
// - Result and limits compared on common lux scale
// - Low flag after enough consecutive below-limit results
// - High flag after enough consecutive above-limit results
// - High comparison ignores mask bit
// - Range 1100b automatic, below is manual
`timescale 1ns/10ps
module ltc_threshold
    import ltc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Conversion results
    input wire logic conv_done,
    input wire logic [3:0] conv_exp,
    input wire logic [11:0] conv_mant,
    // Status and control to the conversion engine
    output logic [3:0] range_select,
    output logic above_limit_flag,
    output logic below_limit_flag
);
    // Common lux scale in units of 0.01 lux: mantissa shifted by exponent
    function automatic logic [LTC_LUX_W-1:0] to_lux(input logic [3:0] e,
                                                    input logic [11:0] m);
        to_lux = LTC_LUX_W'(m) << e;
    endfunction

    logic [3:0] range_reg;
    logic [3:0] range_next;
    logic mask_reg;
    logic mask_next;
    logic [1:0] fault_sel_reg;
    logic [1:0] fault_sel_next;
    logic [15:0] low_reg;
    logic [15:0] low_next;
    logic [15:0] high_reg;
    logic [15:0] high_next;
    logic [15:0] result_reg;
    logic [15:0] result_next;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [3:0] range_out_reg;
    logic above_reg;
    logic below_reg;
    logic eval_reg;
    logic eval_next;
    logic viol_hi_reg;
    logic viol_hi_next;
    logic viol_lo_reg;
    logic viol_lo_next;
    logic [LTC_LUX_W-1:0] lux_res;
    logic above_flag;
    logic below_flag;
    logic manual_masked;
    logic [15:0] result_view;
    logic [15:0] cfg_view;

    // Registers and comparison pipeline
    always_comb begin
        range_next = range_reg;
        mask_next = mask_reg;
        fault_sel_next = fault_sel_reg;
        low_next = low_reg;
        high_next = high_reg;
        result_next = result_reg;
        if (reg_wr) begin
            case (reg_addr)
                LTC_OFF_CONFIG: begin
                    range_next = reg_wdata[LTC_CFG_RANGE_LSB +: 4];
                    mask_next = reg_wdata[LTC_CFG_MASK];
                    fault_sel_next = reg_wdata[LTC_CFG_FAULT_LSB +: 2];
                end
                LTC_OFF_LOW: begin
                    low_next = reg_wdata;
                end
                LTC_OFF_HIGH: begin
                    high_next = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        // Unmasked measurement is stored; masking is applied on read only
        lux_res = to_lux(conv_exp, conv_mant);
        eval_next = conv_done;
        viol_hi_next = viol_hi_reg;
        viol_lo_next = viol_lo_reg;
        if (conv_done) begin
            result_next = {conv_exp, conv_mant};
            viol_lo_next = lux_res < to_lux(low_reg[LTC_EXP_LSB +: 4],
                                            low_reg[LTC_MANT_W-1:0]);
            viol_hi_next = lux_res > to_lux(high_reg[LTC_EXP_LSB +: 4],
                                            high_reg[LTC_MANT_W-1:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            range_reg <= LTC_RANGE_RST;
            mask_reg <= LTC_MASK_RST;
            fault_sel_reg <= LTC_FAULT_RST;
            low_reg <= LTC_LOW_RST;
            high_reg <= LTC_HIGH_RST;
            result_reg <= '0;
            eval_reg <= 1'b0;
            viol_hi_reg <= 1'b0;
            viol_lo_reg <= 1'b0;
        end else begin
            range_reg <= range_next;
            mask_reg <= mask_next;
            fault_sel_reg <= fault_sel_next;
            low_reg <= low_next;
            high_reg <= high_next;
            result_reg <= result_next;
            eval_reg <= eval_next;
            viol_hi_reg <= viol_hi_next;
            viol_lo_reg <= viol_lo_next;
        end
    end

    // One counter per limit, evaluated once per completed conversion
    ltc_fault_counter #(
        .CNT_W(4)
    ) u_high_count (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .eval(eval_reg),
        .violate(viol_hi_reg),
        .fault_count_sel(fault_sel_reg),
        .flag(above_flag)
    );

    ltc_fault_counter #(
        .CNT_W(4)
    ) u_low_count (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .eval(eval_reg),
        .violate(viol_lo_reg),
        .fault_count_sel(fault_sel_reg),
        .flag(below_flag)
    );

    // Read path
    always_comb begin
        manual_masked = mask_reg && (range_reg < LTC_RANGE_AUTO);
        result_view = result_reg;
        if (manual_masked) begin
            result_view[LTC_EXP_LSB +: 4] = 4'h0;
        end
        cfg_view = '0;
        cfg_view[LTC_CFG_RANGE_LSB +: 4] = range_reg;
        cfg_view[LTC_CFG_HIGH_FLAG] = above_flag;
        cfg_view[LTC_CFG_LOW_FLAG] = below_flag;
        cfg_view[LTC_CFG_LATCH] = LTC_LATCH_VAL;
        cfg_view[LTC_CFG_MASK] = mask_reg;
        cfg_view[LTC_CFG_FAULT_LSB +: 2] = fault_sel_reg;
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                LTC_OFF_RESULT: rdata_next = result_view;
                LTC_OFF_CONFIG: rdata_next = cfg_view;
                LTC_OFF_LOW: rdata_next = low_reg;
                LTC_OFF_HIGH: rdata_next = high_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
            range_out_reg <= LTC_RANGE_RST;
            above_reg <= 1'b0;
            below_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            range_out_reg <= range_next;
            above_reg <= above_flag;
            below_reg <= below_flag;
        end
    end

    assign reg_rdata = rdata_reg;
    assign range_select = range_out_reg;
    assign above_limit_flag = above_reg;
    assign below_limit_flag = below_reg;
endmodule

//--- ltc_threshold_sva.sv
`timescale 1ns/10ps
module ltc_threshold_sva
    import ltc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Registers
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Conversion and flags
    input wire logic conv_done,
    input wire logic [3:0] conv_exp,
    input wire logic [11:0] conv_mant,
    input wire logic [3:0] range_select,
    input wire logic above_limit_flag,
    input wire logic below_limit_flag
);
    logic [15:0] lo_reg;
    logic [15:0] hi_reg;
    logic [2:0] cf_reg;
    logic lo_v;
    logic hi_v;
    // Shadow limits and low config bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            lo_reg <= 16'h0000;
            hi_reg <= 16'hbfff;
            cf_reg <= 3'h0;
        end else if (reg_wr) begin
            if (reg_addr == LTC_OFF_LOW) lo_reg <= reg_wdata;
            if (reg_addr == LTC_OFF_HIGH) hi_reg <= reg_wdata;
            if (reg_addr == LTC_OFF_CONFIG) cf_reg <= reg_wdata[2:0];
        end
    end
    assign lo_v = (27'(conv_mant) << conv_exp) < (27'(lo_reg[11:0]) << lo_reg[15:12]);
    assign hi_v = (27'(conv_mant) << conv_exp) > (27'(hi_reg[11:0]) << hi_reg[15:12]);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_quiet;
        !conv_done ##1 !conv_done ##1 !conv_done;
    endsequence
    a_low_set:
        assert property (conv_done && cf_reg[1:0] == 2'h0 && lo_v |-> ##3 below_limit_flag)
        else $error("low flag not raised");
    a_low_clear:
        assert property (conv_done && !lo_v |-> ##3 !below_limit_flag)
        else $error("low flag not cleared");
    a_high_set:
        assert property (conv_done && cf_reg[1:0] == 2'h0 && hi_v |-> ##3 above_limit_flag)
        else $error("high flag not raised");
    a_high_clear:
        assert property (conv_done && !hi_v |-> ##3 !above_limit_flag)
        else $error("high flag not cleared");
    a_flags_hold:
        assert property (s_quiet |=> $stable(below_limit_flag) && $stable(above_limit_flag))
        else $error("flag moved without conversion");
    a_range_follow:
        assert property (reg_wr && reg_addr == LTC_OFF_CONFIG |=>
            range_select == $past(reg_wdata[15:12]))
        else $error("range select not updated");
    a_rdata_hold:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_mask_result:
        assert property (reg_rd && reg_addr == LTC_OFF_RESULT && cf_reg[2] &&
            range_select < 4'hc |=> reg_rdata[15:12] == 4'h0)
        else $error("result exponent not masked");
endmodule

//--- ltc_conv_src.sv
`timescale 1ns/10ps
module ltc_conv_src (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Request from the bench
    input wire logic start,
    input wire logic [3:0] exp_in,
    input wire logic [11:0] mant_in,
    // Toward the block
    output logic conv_done,
    output logic [3:0] conv_exp,
    output logic [11:0] conv_mant
);
    // Result lines are valid only with the pulse, scrambled otherwise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_done <= 1'b0;
            conv_exp <= 4'h0;
            conv_mant <= 12'h000;
        end else begin
            conv_done <= start;
            conv_exp <= start ? exp_in : ~conv_exp;
            conv_mant <= start ? mant_in : ~conv_mant;
        end
    end
endmodule

//--- ltc_threshold_tb.sv
`timescale 1ns/10ps
module ltc_threshold_tb
    import ltc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic start = 1'b0;
    logic [3:0] exp_in = 4'h0;
    logic [11:0] mant_in = 12'h000;
    logic conv_done;
    logic [3:0] conv_exp;
    logic [11:0] conv_mant;
    logic [3:0] range_select;
    logic above_limit_flag;
    logic below_limit_flag;
    int num_errors = 0;
    int checked = 0;
    always #5 ref_clk = ~ref_clk;
    ltc_conv_src u_src(.ref_clk(ref_clk), .rst_b(rst_b), .start(start), .exp_in(exp_in),
        .mant_in(mant_in), .conv_done(conv_done), .conv_exp(conv_exp), .conv_mant(conv_mant));
    ltc_threshold u_dut(.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_done(conv_done), .conv_exp(conv_exp), .conv_mant(conv_mant),
        .range_select(range_select), .above_limit_flag(above_limit_flag),
        .below_limit_flag(below_limit_flag));
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // One conversion, then both flags three edges after the pulse
    task automatic conv(input logic [15:0] r, input logic lo, input logic hi);
        @(posedge ref_clk);
        start <= 1'b1;
        exp_in <= r[15:12];
        mant_in <= r[11:0];
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("below_limit_flag", 16'(lo), 16'(below_limit_flag));
        chk("above_limit_flag", 16'(hi), 16'(above_limit_flag));
    endtask
    task automatic summarize();
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(LTC_OFF_CONFIG, 16'hc010);
        rd(LTC_OFF_LOW, 16'h0000);
        rd(LTC_OFF_HIGH, 16'hbfff);
        rd(8'h55, 16'h0000);
        wr(LTC_OFF_LOW, 16'h0100);
        rd(LTC_OFF_LOW, 16'h0100);
        for (int code = 0; code < 4; code++) begin
            wr(LTC_OFF_CONFIG, 16'hc000 | 16'(code));
            for (int n = 1; n < (1 << code); n++) begin
                conv(16'h0050, 1'b0, 1'b0);
            end
            conv(16'h0050, 1'b1, 1'b0);
            rd(LTC_OFF_CONFIG, 16'hc030 | 16'(code));
            conv(16'h0200, 1'b0, 1'b0);
        end
        wr(LTC_OFF_CONFIG, 16'hc000);
        wr(LTC_OFF_LOW, 16'h1080);
        conv(16'h00ff, 1'b1, 1'b0);
        conv(16'h8001, 1'b0, 1'b0);
        conv(16'hcfff, 1'b0, 1'b1);
        conv(16'hbfff, 1'b0, 1'b0);
        // Manual range 3 with masking, limits carry the same exponent
        wr(LTC_OFF_CONFIG, 16'h3004);
        wr(LTC_OFF_LOW, 16'h3020);
        wr(LTC_OFF_HIGH, 16'h3010);
        conv(16'h5010, 1'b0, 1'b1);
        rd(LTC_OFF_RESULT, 16'h0010);
        rd(LTC_OFF_CONFIG, 16'h3054);
        wr(LTC_OFF_CONFIG, 16'hc004);
        rd(LTC_OFF_RESULT, 16'h5010);
        chk("range_select", 16'h000c, 16'(range_select));
        summarize();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
endmodule
bind ltc_threshold ltc_threshold_sva u_sva(.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_exp(conv_exp),
    .conv_mant(conv_mant), .range_select(range_select),
    .above_limit_flag(above_limit_flag), .below_limit_flag(below_limit_flag));
